// ### hw/fcb_pkg.sv
// Constants for the flag clear-on-read register bank.
// Assumes a 32-bit AXI4-Lite bus with byte addresses as printed.
package fcb_pkg;

    // Register byte addresses
    localparam logic [31:0] OFS_RX_OVERFLOW_CLEAR_BIT  = 32'h5000_1348;
    localparam logic [31:0] OFS_TX_OVERFLOW_CLEAR_BIT  = 32'h5000_134C;
    localparam logic [31:0] OFS_READ_REQUEST_CLEAR_BIT   = 32'h5000_1350;
    localparam logic [31:0] OFS_TRANSMIT_ABORT_CLEAR_BIT  = 32'h5000_1354;
    localparam logic [31:0] OFS_RECEIVE_DONE_CLEAR_BIT  = 32'h5000_1358;
    localparam logic [31:0] OFS_ACTIVITY_CLEAR_BIT = 32'h5000_135C;
    localparam logic [31:0] OFS_CLR_STOP     = 32'h5000_1360;
    localparam logic [31:0] OFS_CLR_START    = 32'h5000_1364;
    localparam logic [31:0] OFS_GENERAL_CALL_CLEAR_BIT = 32'h5000_1368;
    localparam logic [31:0] OFS_CTRL_ON      = 32'h5000_136C;
    localparam logic [31:0] OFS_RAW_STATUS   = 32'h5000_13A0;
    localparam logic [31:0] OFS_FLAG_MASK    = 32'h5000_13A4;
    localparam logic [31:0] OFS_ABORT_CAUSE  = 32'h5000_13A8;

    // Flag positions in the raw flag status register
    localparam int BIT_RX_OVER  = 1;
    localparam int BIT_TX_OVER  = 3;
    localparam int BIT_RD_REQ   = 5;
    localparam int BIT_TRANSMIT_ABORT_FLAG  = 6;
    localparam int BIT_RX_DONE  = 7;
    localparam int BIT_ACTIVITY = 8;
    localparam int BIT_STOP     = 9;
    localparam int BIT_START    = 10;
    localparam int BIT_GENERAL_CALL_FLAG = 11;

    // Abort cause bit that survives the abort-clear read
    localparam int BIT_CAUSE_KEEP = 9;

    // Field widths
    localparam int FLAG_W = 12;
    localparam int REG_W  = 16;

    // Flags that exist; the others read as zero
    localparam logic [11:0] FLAG_IMPL = 12'hFEA;

    // Reset values
    localparam logic [11:0] RST_FLAGS = 12'h000;
    localparam logic [11:0] RST_MASK  = 12'h000;
    localparam logic [15:0] RST_CAUSE = 16'h0000;
    localparam logic        RST_CTRL  = 1'b0;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Receive FIFO depth
    localparam int RX_DEPTH = 32;

endpackage

// ### hw/fcb_flag_bank.sv
// Flag clear-on-read register bank with AXI4-Lite slave port.
// Assumes flag events arrive as one-cycle pulses synchronous to i_clk.
// Assumes the bus master keeps at most one read and one write under way.
// Clear registers are read-only; a write to them is answered with SLVERR.
`timescale 1ns/1ps

module fcb_flag_bank #(
    parameter int RX_DEPTH = fcb_pkg::RX_DEPTH
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // AXI4-Lite write address
    input  wire logic [31:0] i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    // AXI4-Lite write response
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    // AXI4-Lite read address
    input  wire logic [31:0] i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    // AXI4-Lite read data
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    // Controller side
    input  wire logic [11:0] i_flag_set,
    input  wire logic        i_bus_active,
    input  wire logic [15:0] i_abort_cause,
    input  wire logic        i_rx_byte_in,
    input  wire logic [5:0]  i_rx_level,
    output logic             o_ctrl_on,
    output logic             o_tx_fifo_erase,
    output logic             o_rx_fifo_erase,
    output logic             o_rx_byte_drop,
    output logic             o_irq
);

    // State registers
    logic [11:0] flags_r;
    logic [11:0] mask_r;
    logic [15:0] cause_r;
    logic        ctrl_on_r;
    logic        tx_hold_r;
    logic        aw_have_r;
    logic        w_have_r;
    logic [31:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;

    // Next values
    logic [11:0] flags_nxt;
    logic [15:0] cause_nxt;
    logic        ctrl_on_nxt;
    logic        tx_hold_nxt;
    logic [11:0] mask_nxt;

    // Handshake terms
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic ar_take;
    logic r_done;
    assign aw_take = i_awvalid & o_awready;
    assign w_take  = i_wvalid & o_wready;
    assign wr_fire = aw_have_r & w_have_r & ~o_bvalid;
    assign ar_take = i_arvalid & o_arready;
    assign r_done  = o_rvalid & i_rready;

    // Read address decode
    logic rd_rx_over;
    logic rd_tx_over;
    logic rd_rd_req;
    logic rd_transmit_abort_flag;
    logic rd_rx_done;
    logic rd_act;
    logic rd_stop;
    logic rd_start;
    logic rd_general_call_flag;
    logic rd_ctrl;
    logic rd_raw;
    logic rd_mask;
    logic rd_cause;
    logic rd_hit;
    assign rd_rx_over  = (i_araddr == fcb_pkg::OFS_RX_OVERFLOW_CLEAR_BIT);
    assign rd_tx_over  = (i_araddr == fcb_pkg::OFS_TX_OVERFLOW_CLEAR_BIT);
    assign rd_rd_req   = (i_araddr == fcb_pkg::OFS_READ_REQUEST_CLEAR_BIT);
    assign rd_transmit_abort_flag  = (i_araddr == fcb_pkg::OFS_TRANSMIT_ABORT_CLEAR_BIT);
    assign rd_rx_done  = (i_araddr == fcb_pkg::OFS_RECEIVE_DONE_CLEAR_BIT);
    assign rd_act      = (i_araddr == fcb_pkg::OFS_ACTIVITY_CLEAR_BIT);
    assign rd_stop     = (i_araddr == fcb_pkg::OFS_CLR_STOP);
    assign rd_start    = (i_araddr == fcb_pkg::OFS_CLR_START);
    assign rd_general_call_flag = (i_araddr == fcb_pkg::OFS_GENERAL_CALL_CLEAR_BIT);
    assign rd_ctrl     = (i_araddr == fcb_pkg::OFS_CTRL_ON);
    assign rd_raw      = (i_araddr == fcb_pkg::OFS_RAW_STATUS);
    assign rd_mask     = (i_araddr == fcb_pkg::OFS_FLAG_MASK);
    assign rd_cause    = (i_araddr == fcb_pkg::OFS_ABORT_CAUSE);
    assign rd_hit      = rd_rx_over | rd_tx_over | rd_rd_req | rd_transmit_abort_flag | rd_rx_done | rd_act
                       | rd_stop | rd_start | rd_general_call_flag | rd_ctrl | rd_raw | rd_mask | rd_cause;

    // Read data selection, bit 0 of a clear register shows its flag
    logic [15:0] rd_val;
    assign rd_val =
        rd_rx_over  ? {15'h0000, flags_r[fcb_pkg::BIT_RX_OVER]}  :
        rd_tx_over  ? {15'h0000, flags_r[fcb_pkg::BIT_TX_OVER]}  :
        rd_rd_req   ? {15'h0000, flags_r[fcb_pkg::BIT_RD_REQ]}   :
        rd_transmit_abort_flag  ? {15'h0000, flags_r[fcb_pkg::BIT_TRANSMIT_ABORT_FLAG]}  :
        rd_rx_done  ? {15'h0000, flags_r[fcb_pkg::BIT_RX_DONE]}  :
        rd_act      ? {15'h0000, flags_r[fcb_pkg::BIT_ACTIVITY]} :
        rd_stop     ? {15'h0000, flags_r[fcb_pkg::BIT_STOP]}     :
        rd_start    ? {15'h0000, flags_r[fcb_pkg::BIT_START]}    :
        rd_general_call_flag ? {15'h0000, flags_r[fcb_pkg::BIT_GENERAL_CALL_FLAG]} :
        rd_ctrl     ? {15'h0000, ctrl_on_r}                      :
        rd_raw      ? {4'h0, flags_r}                            :
        rd_mask     ? {4'h0, mask_r}                             :
        rd_cause    ? cause_r                                    :
        16'h0000;

    // Clear pulses raised by an accepted read, one wire per register
    logic rx_overflow_clear_bit;
    logic tx_overflow_clear_bit;
    logic read_request_clear_bit;
    logic abrt_clr;
    logic receive_done_clear_bit;
    logic clr_act;
    logic clr_stop;
    logic clr_start;
    logic general_call_clear_bit;
    assign rx_overflow_clear_bit  = ar_take & rd_rx_over;
    assign tx_overflow_clear_bit  = ar_take & rd_tx_over;
    assign read_request_clear_bit   = ar_take & rd_rd_req;
    assign abrt_clr     = ar_take & rd_transmit_abort_flag;
    assign receive_done_clear_bit  = ar_take & rd_rx_done;
    assign clr_act      = ar_take & rd_act;
    assign clr_stop     = ar_take & rd_stop;
    assign clr_start    = ar_take & rd_start;
    assign general_call_clear_bit = ar_take & rd_general_call_flag;

    // Clear pulses gathered into the flag layout
    logic [11:0] rd_clr;
    always_comb begin
        rd_clr = 12'h000;
        rd_clr[fcb_pkg::BIT_RX_OVER]  = rx_overflow_clear_bit;
        rd_clr[fcb_pkg::BIT_TX_OVER]  = tx_overflow_clear_bit;
        rd_clr[fcb_pkg::BIT_RD_REQ]   = read_request_clear_bit;
        rd_clr[fcb_pkg::BIT_TRANSMIT_ABORT_FLAG]  = abrt_clr;
        rd_clr[fcb_pkg::BIT_RX_DONE]  = receive_done_clear_bit;
        rd_clr[fcb_pkg::BIT_ACTIVITY] = clr_act;
        rd_clr[fcb_pkg::BIT_STOP]     = clr_stop;
        rd_clr[fcb_pkg::BIT_START]    = clr_start;
        rd_clr[fcb_pkg::BIT_GENERAL_CALL_FLAG] = general_call_clear_bit;
    end

    // Write decode and byte-lane masks
    logic        wr_ctrl;
    logic        wr_raw;
    logic        wr_mask;
    logic        wr_hit;
    logic [11:0] wr_lanes;
    assign wr_ctrl  = wr_fire & (aw_addr_r == fcb_pkg::OFS_CTRL_ON);
    assign wr_raw   = wr_fire & (aw_addr_r == fcb_pkg::OFS_RAW_STATUS);
    assign wr_mask  = wr_fire & (aw_addr_r == fcb_pkg::OFS_FLAG_MASK);
    assign wr_hit   = (aw_addr_r == fcb_pkg::OFS_CTRL_ON) | (aw_addr_r == fcb_pkg::OFS_RAW_STATUS)
                    | (aw_addr_r == fcb_pkg::OFS_FLAG_MASK);
    assign wr_lanes = {{4{w_strb_r[1]}}, {8{w_strb_r[0]}}};

    // Overflow of the receive FIFO drops the arriving byte
    logic rx_over_evt;
    assign rx_over_evt = i_rx_byte_in & (32'(i_rx_level) >= 32'(RX_DEPTH));

    // Per-flag set and clear terms
    logic [11:0] set_vec;
    logic [11:0] clr_vec;
    logic        act_auto_clr;
    assign act_auto_clr = ~ctrl_on_r;

    // Set and clear vectors, activity kept set while busy
    always_comb begin
        set_vec = i_flag_set;
        set_vec[fcb_pkg::BIT_RX_OVER]  = i_flag_set[fcb_pkg::BIT_RX_OVER] | rx_over_evt;
        set_vec[fcb_pkg::BIT_ACTIVITY] = i_flag_set[fcb_pkg::BIT_ACTIVITY] | i_bus_active;
        clr_vec = rd_clr | ({12{wr_raw}} & wr_lanes & w_data_r[11:0]);
        clr_vec[fcb_pkg::BIT_ACTIVITY] = clr_vec[fcb_pkg::BIT_ACTIVITY] | act_auto_clr;
    end

    // Sticky flags, a set in the clear cycle wins
    genvar g;
    generate
        for (g = 0; g < fcb_pkg::FLAG_W; g++) begin : g_flag
            if (fcb_pkg::FLAG_IMPL[g]) begin : g_impl
                assign flags_nxt[g] = set_vec[g] | (flags_r[g] & ~clr_vec[g]);
            end else begin : g_none
                assign flags_nxt[g] = 1'b0;
            end
        end
    endgenerate

    // Abort cause keeps bit 9 over the clear read, dropped when off
    logic [15:0] cause_clr;
    always_comb begin
        cause_clr = {16{abrt_clr}};
        cause_clr[fcb_pkg::BIT_CAUSE_KEEP] = ~ctrl_on_r;
    end
    // New causes OR in, so a same-cycle cause wins over the clear
    assign cause_nxt = i_abort_cause | (cause_r & ~cause_clr);

    // Transmit flush hold from abort until the abort-clear read
    assign tx_hold_nxt = i_flag_set[fcb_pkg::BIT_TRANSMIT_ABORT_FLAG] | (tx_hold_r & ~abrt_clr);

    // Enable bit, written through the low byte lane only
    assign ctrl_on_nxt = (wr_ctrl & w_strb_r[0]) ? w_data_r[0] : ctrl_on_r;

    // Mask write merges per byte lane
    assign mask_nxt    = wr_mask ? ((w_data_r[11:0] & wr_lanes) | (mask_r & ~wr_lanes)) : mask_r;

    // Raw flag state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags_r <= fcb_pkg::RST_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Interrupt mask state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mask_r <= fcb_pkg::RST_MASK;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // Abort cause state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cause_r <= fcb_pkg::RST_CAUSE;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // Controller enable state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_on_r <= fcb_pkg::RST_CTRL;
        end else begin
            ctrl_on_r <= ctrl_on_nxt;
        end
    end

    // Transmit flush hold state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_hold_r <= 1'b0;
        end else begin
            tx_hold_r <= tx_hold_nxt;
        end
    end

    // Enable mirror for the controller
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ctrl_on <= 1'b0;
        end else begin
            o_ctrl_on <= ctrl_on_nxt;
        end
    end

    // FIFO erase holds, both on while disabled, transmit also on while an abort is pending
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_tx_fifo_erase <= 1'b1;
            o_rx_fifo_erase <= 1'b1;
        end else begin
            o_tx_fifo_erase <= tx_hold_nxt | ~ctrl_on_nxt;
            o_rx_fifo_erase <= ~ctrl_on_nxt;
        end
    end

    // Drop pulse and interrupt level
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rx_byte_drop <= 1'b0;
            o_irq          <= 1'b0;
        end else begin
            o_rx_byte_drop <= rx_over_evt;
            o_irq          <= |(flags_nxt & mask_nxt);
        end
    end

    // Write address capture, in either order with the data
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 32'h0000_0000;
            o_awready <= 1'b1;
        end else begin
            if (aw_take) begin
                aw_addr_r <= i_awaddr;
            end
            aw_have_r <= (aw_have_r | aw_take) & ~wr_fire;
            o_awready <= ~((aw_have_r | aw_take) & ~wr_fire) & ~(o_bvalid & ~i_bready);
        end
    end

    // Write data capture, in either order with the address
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            w_have_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            o_wready <= 1'b1;
        end else begin
            if (w_take) begin
                w_data_r <= i_wdata;
                w_strb_r <= i_wstrb;
            end
            w_have_r <= (w_have_r | w_take) & ~wr_fire;
            o_wready <= ~((w_have_r | w_take) & ~wr_fire) & ~(o_bvalid & ~i_bready);
        end
    end

    // Write response
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_bvalid <= 1'b0;
            o_bresp  <= fcb_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp  <= wr_hit ? fcb_pkg::RESP_OKAY : fcb_pkg::RESP_SLVERR;
        end else if (o_bvalid & i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // Read channel, one read under way at a time
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= fcb_pkg::RESP_OKAY;
        end else if (ar_take) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= {16'h0000, rd_val};
            o_rresp   <= rd_hit ? fcb_pkg::RESP_OKAY : fcb_pkg::RESP_SLVERR;
        end else if (r_done) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
        end
    end

endmodule

// ### verif/fcb_flag_bank_checker.sv
// Port-level assertions for the flag clear-on-read bank.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps

module fcb_flag_bank_checker #(
    parameter int RX_DEPTH = 32
) (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [31:0] i_araddr,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0]  o_rresp,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic [11:0] i_flag_set,
    input wire logic        i_bus_active,
    input wire logic        i_rx_byte_in,
    input wire logic [5:0]  i_rx_level,
    input wire logic        o_ctrl_on,
    input wire logic        o_tx_fifo_erase,
    input wire logic        o_rx_fifo_erase,
    input wire logic        o_rx_byte_drop
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Read address taken, and the notable clear reads
    sequence ar_take;
        i_arvalid && o_arready;
    endsequence
    sequence abort_rd;
        ar_take ##0 (i_araddr == fcb_pkg::OFS_TRANSMIT_ABORT_CLEAR_BIT);
    endsequence
    sequence busy_activity_rd;
        ar_take ##0 (i_araddr == fcb_pkg::OFS_ACTIVITY_CLEAR_BIT && i_bus_active && $past(i_bus_active));
    endsequence

    // Bus handshake and payload holding
    read_answer_a: assert property (ar_take |=> o_rvalid && !o_arready)
        else $error("read answer missing after address taken");
    rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
        else $error("read data changed before rready");
    bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response changed before bready");
    clear_word_a: assert property (ar_take ##0 (i_araddr[1:0] == 2'h0
        && i_araddr inside {[fcb_pkg::OFS_RX_OVERFLOW_CLEAR_BIT:fcb_pkg::OFS_GENERAL_CALL_CLEAR_BIT]})
        |=> o_rdata[31:1] == 31'h0 && o_rresp == fcb_pkg::RESP_OKAY)
        else $error("clear register read returned reserved bits");
    // Controller side behaviour
    rx_drop_a: assert property (1'b1 |=> o_rx_byte_drop == $past(i_rx_byte_in && i_rx_level >= RX_DEPTH))
        else $error("byte drop pulse wrong");
    fifo_erase_a: assert property (!o_ctrl_on && $past(!o_ctrl_on) |-> o_tx_fifo_erase && o_rx_fifo_erase)
        else $error("fifo not erased while disabled");
    abort_release_a: assert property (abort_rd ##0 (o_ctrl_on && !i_flag_set[6]) |-> ##[1:2] !o_tx_fifo_erase)
        else $error("transmit fifo not released by abort clear");
    activity_busy_a: assert property (busy_activity_rd |=> o_rdata[0])
        else $error("activity flag not reported while busy");
endmodule

bind fcb_flag_bank fcb_flag_bank_checker #(.RX_DEPTH(RX_DEPTH)) chk_u (.*);

// ### verif/i2c_flag_clear_on_read_bank_test.sv
// Self-checking bench for the flag clear-on-read bank over AXI4-Lite.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps

module i2c_flag_clear_on_read_bank_test;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0;
    logic [3:0]  i_wstrb = 4'hF;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic [11:0] i_flag_set = 12'h000;
    logic        i_bus_active = 1'b0, i_rx_byte_in = 1'b0;
    logic [15:0] i_abort_cause = 16'h0000;
    logic [5:0]  i_rx_level = 6'h00;
    logic [31:0] o_rdata, rv, lfsr = 32'hC9106EBF;
    logic [1:0]  o_bresp, o_rresp, rs;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic        o_ctrl_on, o_tx_fifo_erase, o_rx_fifo_erase, o_rx_byte_drop, o_irq;
    logic [11:0] exp_raw = 12'h000, msk;
    int          bad_count = 0, comparisons = 0, cycles = 0;
    logic [31:0] clr_addr [8] = '{fcb_pkg::OFS_RX_OVERFLOW_CLEAR_BIT, fcb_pkg::OFS_TX_OVERFLOW_CLEAR_BIT, fcb_pkg::OFS_READ_REQUEST_CLEAR_BIT,
        fcb_pkg::OFS_TRANSMIT_ABORT_CLEAR_BIT, fcb_pkg::OFS_RECEIVE_DONE_CLEAR_BIT, fcb_pkg::OFS_CLR_STOP, fcb_pkg::OFS_CLR_START,
        fcb_pkg::OFS_GENERAL_CALL_CLEAR_BIT};
    int          clr_bit [8] = '{1, 3, 5, 6, 7, 9, 10, 11};

    fcb_flag_bank dut_u (.*);

    // Clock and hang guard
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            summarize();
        end
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("FAIL %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    // Write: both channels offered together, response awaited
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!done) begin
            @(posedge i_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (o_bvalid) begin
                rs = o_bresp;
                i_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // Read: address held until taken, data taken at rvalid
    task automatic rd(input logic [31:0] a);
        logic done;
        done = 1'b0;
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        while (!done) begin
            @(posedge i_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (o_rvalid) begin
                rv = o_rdata;
                rs = o_rresp;
                i_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic pulse(input logic [11:0] f);
        @(posedge i_clk);
        i_flag_set <= f;
        @(posedge i_clk);
        i_flag_set <= 12'h000;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        check({o_tx_fifo_erase, o_rx_fifo_erase, o_ctrl_on, o_irq}, 4'hC);
        // Each clear register except activity: value before the pulse, set flag with random others, read-clear
        for (int i = 0; i < 8; i++) begin
            rd(clr_addr[i]);
            check(rv, exp_raw[clr_bit[i]]);
            lfsr = next_rand(lfsr);
            exp_raw = exp_raw | (lfsr[11:0] & fcb_pkg::FLAG_IMPL & 12'hEFF) | (12'h001 << clr_bit[i]);
            pulse(lfsr[11:0] & 12'hEFF | (12'h001 << clr_bit[i]));
            rd(fcb_pkg::OFS_RAW_STATUS);
            check(rv, exp_raw);
            rd(clr_addr[i]);
            check(rv, 32'h1);
            exp_raw[clr_bit[i]] = 1'b0;
            rd(fcb_pkg::OFS_RAW_STATUS);
            check(rv, exp_raw);
        end
        $display("test clear registers done");
        // Abort clear with controller enabled
        wr(fcb_pkg::OFS_CTRL_ON, 32'h1);
        check(o_ctrl_on, 1'b1);
        rd(fcb_pkg::OFS_CTRL_ON);
        check(rv, 32'h1);
        @(posedge i_clk);
        i_abort_cause <= 16'h0241;
        @(posedge i_clk);
        i_abort_cause <= 16'h0000;
        pulse(12'h040);
        rd(fcb_pkg::OFS_ABORT_CAUSE);
        check(rv, 32'h241);
        check(o_tx_fifo_erase, 1'b1);
        rd(fcb_pkg::OFS_TRANSMIT_ABORT_CLEAR_BIT);
        check(rv, 32'h1);
        rd(fcb_pkg::OFS_ABORT_CAUSE);
        check(rv, 32'h200);
        check(o_tx_fifo_erase, 1'b0);
        $display("test abort clear done");
        // Activity: held while busy, cleared when idle, auto-cleared when disabled
        i_bus_active <= 1'b1;
        rd(fcb_pkg::OFS_ACTIVITY_CLEAR_BIT);
        check(rv, 32'h1);
        rd(fcb_pkg::OFS_RAW_STATUS);
        check(rv[8], 1'b1);
        i_bus_active <= 1'b0;
        rd(fcb_pkg::OFS_ACTIVITY_CLEAR_BIT);
        rd(fcb_pkg::OFS_RAW_STATUS);
        check(rv[8], 1'b0);
        rd(fcb_pkg::OFS_ACTIVITY_CLEAR_BIT);
        check(rv, 32'h0);
        i_bus_active <= 1'b1;
        wr(fcb_pkg::OFS_CTRL_ON, 32'h0);
        i_bus_active <= 1'b0;
        rd(fcb_pkg::OFS_RAW_STATUS);
        check(rv[8], 1'b0);
        check({o_tx_fifo_erase, o_rx_fifo_erase}, 2'h3);
        $display("test activity done");
        // Receive overflow at the depth boundary, stale flag flushed first
        rd(fcb_pkg::OFS_RX_OVERFLOW_CLEAR_BIT);
        for (int lv = 31; lv < 33; lv++) begin
            i_rx_level <= 6'(lv);
            i_rx_byte_in <= 1'b1;
            @(posedge i_clk);
            i_rx_byte_in <= 1'b0;
            #1 check(o_rx_byte_drop, 32'(lv == 32));
            rd(fcb_pkg::OFS_RX_OVERFLOW_CLEAR_BIT);
            check(rv, 32'(lv == 32));
        end
        $display("test overflow done");
        // Mask, interrupt, write-one-to-clear and unmapped access
        lfsr = next_rand(lfsr);
        msk = (lfsr[11:0] | 12'h008) & 12'hFDF;
        wr(fcb_pkg::OFS_RAW_STATUS, 32'hFFF);
        rd(fcb_pkg::OFS_RAW_STATUS);
        check(rv, 32'h0);
        wr(fcb_pkg::OFS_FLAG_MASK, {20'h0, msk});
        rd(fcb_pkg::OFS_FLAG_MASK);
        check(rv, {20'h0, msk});
        pulse(12'h020);
        @(posedge i_clk);
        check(o_irq, 1'b0);
        pulse(12'h008);
        @(posedge i_clk);
        check(o_irq, 1'b1);
        wr(fcb_pkg::OFS_RAW_STATUS, 32'h28);
        check(o_irq, 1'b0);
        rd(32'h5000_1300);
        check(rs, fcb_pkg::RESP_SLVERR);
        check(rv, 32'h0);
        wr(32'h5000_1300, 32'hFFFF);
        check(rs, fcb_pkg::RESP_SLVERR);
        $display("test interrupt and map done");
        summarize();
    end
endmodule
